// ---- rtl/fgil_pkg.sv ----
package fgil_pkg;

    ////////////////////////////////////////////////////////////////////////
    // word widths
    localparam int DDR_W = 2;
    localparam int SER_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // delay chains, counted in clk_i cycles per step
    localparam int STATIC_STEPS_SE = 16;
    localparam int STATIC_W_SE     = 4;
    localparam int DIFF_STEPS      = 64;
    localparam int DYN_STEPS       = 64;
    localparam int DLY_W           = 6;
    localparam int IDX_W           = 7;
    localparam int DLY_LINE_LEN    = 80;

    localparam logic [DLY_W-1:0] DYN_DELAY_STEP_CLEAR = 6'h00;

endpackage

// ---- rtl/fgil_delay_ctr.sv ----
module fgil_delay_ctr
    import fgil_pkg::*;
#(
    parameter int STEPS = DYN_STEPS,
    parameter int W     = DLY_W
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // step controls from the core
    input  wire logic         step_enable_i,
    input  wire logic         step_direction_i,
    input  wire logic         step_clear_i,
    // current setting
    output logic [W-1:0]      value_o
);

    localparam logic [W-1:0] TOP = W'(STEPS - 1);
    localparam logic [W-1:0] RST = W'(DYN_DELAY_STEP_CLEAR);

    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (step_clear_i) begin
            next_count = RST;
        end else if (step_enable_i) begin
            // one step per enabled clock, held at either end
            if (step_direction_i && count != TOP) begin
                next_count = count + W'(1);
            end else if (!step_direction_i && count != '0) begin
                next_count = count - W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= RST;
        end else begin
            count <= next_count;
        end
    end

    assign value_o = count;

    ////////////////////////////////////////////////////////////////////////
    // checks

    AST_DELAY_STEP_DIRECTION: assert property (@(posedge clk_i) disable iff (rst_i)
        !step_clear_i && step_enable_i && step_direction_i && count != TOP
        |=> count == $past(count) + W'(1))
        else $error("delay did not increment");

    AST_DLY_DEC: assert property (@(posedge clk_i) disable iff (rst_i)
        !step_clear_i && step_enable_i && !step_direction_i && count != '0
        |=> count == $past(count) - W'(1))
        else $error("delay did not decrement");

    AST_DLY_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        step_clear_i |=> count == RST)
        else $error("delay clear ignored");

    AST_DLY_SAT: assert property (@(posedge clk_i) disable iff (rst_i)
        !step_clear_i && count == TOP && step_direction_i |=> count == TOP)
        else $error("delay wrapped at top");

    AST_DLY_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        !step_clear_i && !step_enable_i |=> $stable(count))
        else $error("delay moved without enable");

endmodule

// ---- rtl/fgil_io_logic.sv ----
// Operation
// - dual-edge input samples both edges, two bits
// - normal mode passes bits on each edge
// - resync mode changes both bits on rise
// - falling sample held half period in resync
// - bit0 rising sample, bit1 falling sample
// - bit0 driven high half, bit1 low half
// - deserializer: earliest bit lands at bit0
// - serializer sends bit0 first, bit3 last
// - output and enable registers on launch clock
// - input registers on separate capture clock
// - serial clocks drive serializer and deserializer
// - pad pair: two single-ended or one differential
// - single-ended: sixteen static steps, input and output
// - differential: 64 steps, static xor dynamic
// - dynamic delay 64 steps, input only
// - step enable with direction increments or decrements
// - clear returns dynamic delay to reset
// - serdes works in full-rate mode only
// - optional output inversion, selectable register edge
// - bypass path never passes input register
module fgil_io_logic
    import fgil_pkg::*;
(
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // io clocks, oversampled
    input  wire logic               capture_clock_i,
    input  wire logic               launch_clock_i,
    input  wire logic               capture_serial_clock_i,
    input  wire logic               launch_serial_clock_i,
    // configuration
    input  wire logic               dual_edge_mode_i,
    input  wire logic               resync_mode_i,
    input  wire logic               serdes_en_i,
    input  wire logic               diff_mode_i,
    input  wire logic               in_reg_en_i,
    input  wire logic               in_negedge_i,
    input  wire logic               out_reg_en_i,
    input  wire logic               out_negedge_i,
    input  wire logic               out_invert_i,
    input  wire logic               oe_reg_en_i,
    input  wire logic               oe_negedge_i,
    input  wire logic [DLY_W-1:0]   in_static_delay_i,
    input  wire logic [DLY_W-1:0]   out_static_delay_i,
    input  wire logic               dyn_delay_sel_i,
    // dynamic delay control
    input  wire logic               delay_step_enable_i,
    input  wire logic               delay_step_direction_i,
    input  wire logic               delay_step_clear_i,
    output logic [DLY_W-1:0]        dyn_delay_o,
    // core data
    input  wire logic [SER_W-1:0]   pad_drive_bits_i,
    input  wire logic               drive_enable_i,
    input  wire logic               drive_enable_pair_i,
    output logic [SER_W-1:0]        pad_capture_bits_o,
    output logic                    bypass_path_o,
    // second pad as single-ended io
    input  wire logic               pad_n_drive_i,
    input  wire logic               pad_n_enable_i,
    output logic                    pad_n_capture_o,
    // pads
    input  wire logic               pad_p_i,
    input  wire logic               pad_n_i,
    output logic                    pad_p_o,
    output logic                    pad_p_oe_n_o,
    output logic                    pad_n_o,
    output logic                    pad_n_oe_n_o
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic tap(input logic [DLY_LINE_LEN-1:0] line,
                                 input logic [IDX_W-1:0]        idx,
                                 input logic                    cur);
        if (idx == '0) begin
            tap = cur;
        end else begin
            tap = line[idx - IDX_W'(1)];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    // three stages per clock pin: two to synchronise, one for edges
    logic [2:0]              cap_s, lau_s, cser_s, lser_s;
    logic [1:0]              pp_s, pn_s;
    logic [DLY_LINE_LEN-1:0] dly_in, dly_out;
    logic [SER_W-1:0]        cap_word, deser_sh, ser_sh;
    logic                    fall_hold, ser_bit, sdr_q;
    logic [DDR_W-1:0]        out_hold;
    logic                    oe_q, oen_q;
    logic                    pad_p, pad_p_oe_n, pad_n, pad_n_oe_n;

    logic [DLY_LINE_LEN-1:0] next_dly_in, next_dly_out;
    logic [SER_W-1:0]        next_cap_word, next_deser_sh, next_ser_sh;
    logic                    next_fall_hold, next_ser_bit, next_sdr_q;
    logic [DDR_W-1:0]        next_out_hold;
    logic                    next_oe_q, next_oen_q;
    logic                    next_pad_p, next_pad_p_oe_n;
    logic                    next_pad_n, next_pad_n_oe_n;

    logic             cap_rise, cap_fall, lau_rise, lau_fall;
    logic             cser_rise, lser_rise, in_edge, out_edge, oe_edge;
    logic             din, out_val, oe_val;
    logic [SER_W-1:0] word;
    logic [IDX_W-1:0] in_idx, out_idx;
    logic [DLY_W-1:0] dyn;

    ////////////////////////////////////////////////////////////////////////
    // dynamic delay counter

    fgil_delay_ctr #(
        .STEPS (DYN_STEPS),
        .W     (DLY_W)
    ) u_dyn (
        .clk_i            (clk_i),
        .rst_i            (rst_i),
        .step_enable_i    (delay_step_enable_i),
        .step_direction_i (delay_step_direction_i),
        .step_clear_i     (delay_step_clear_i),
        .value_o          (dyn)
    );

    ////////////////////////////////////////////////////////////////////////
    // next values

    always_comb begin
        // edges seen only on stages 2 and 3
        cap_rise  = cap_s[1] & ~cap_s[2];
        cap_fall  = ~cap_s[1] & cap_s[2];
        lau_rise  = lau_s[1] & ~lau_s[2];
        lau_fall  = ~lau_s[1] & lau_s[2];
        cser_rise = cser_s[1] & ~cser_s[2];
        lser_rise = lser_s[1] & ~lser_s[2];
        in_edge   = in_negedge_i ? cap_fall : cap_rise;
        out_edge  = out_negedge_i ? lau_fall : lau_rise;
        oe_edge   = oe_negedge_i ? lau_fall : lau_rise;

        // input delay: differential picks one source, single-ended adds
        if (diff_mode_i) begin
            in_idx = dyn_delay_sel_i ? IDX_W'(dyn)
                                     : IDX_W'(in_static_delay_i);
            out_idx = IDX_W'(out_static_delay_i);
        end else begin
            in_idx = IDX_W'(in_static_delay_i[STATIC_W_SE-1:0])
                   + IDX_W'(dyn);
            out_idx = IDX_W'(out_static_delay_i[STATIC_W_SE-1:0]);
        end
        // only the P side carries delay and data in differential mode
        din         = tap(dly_in, in_idx, pp_s[1]);
        next_dly_in = {dly_in[DLY_LINE_LEN-2:0], pp_s[1]};

        // input side
        next_cap_word  = cap_word;
        next_deser_sh  = deser_sh;
        next_fall_hold = fall_hold;
        if (serdes_en_i) begin
            // full rate: one bit per serial rising edge only
            if (cser_rise) begin
                next_deser_sh = {din, deser_sh[SER_W-1:1]};
            end
            if (cap_rise) begin
                next_cap_word = deser_sh;
            end
        end else if (dual_edge_mode_i) begin
            next_cap_word[SER_W-1:DDR_W] = '0;
            if (resync_mode_i) begin
                if (cap_fall) begin
                    next_fall_hold = din;
                end
                if (cap_rise) begin
                    next_cap_word[0] = din;
                    next_cap_word[1] = fall_hold;
                end
            end else begin
                if (cap_rise) begin
                    next_cap_word[0] = din;
                end
                if (cap_fall) begin
                    next_cap_word[1] = din;
                end
            end
        end else if (in_reg_en_i) begin
            next_cap_word = '0;
            next_cap_word[0] = in_edge ? din : cap_word[0];
        end else begin
            next_cap_word = {{(SER_W-1){1'b0}}, din};
        end

        // output side; inversion applies to all data bits
        word          = pad_drive_bits_i ^ {SER_W{out_invert_i}};
        next_ser_sh   = ser_sh;
        next_ser_bit  = ser_bit;
        next_out_hold = out_hold;
        next_sdr_q    = sdr_q;
        if (lau_rise) begin
            next_ser_sh   = word;
            next_out_hold = word[DDR_W-1:0];
        end
        if (lser_rise) begin
            next_ser_bit = lau_rise ? word[0] : ser_sh[0];
            next_ser_sh  = lau_rise ? {1'b0, word[SER_W-1:1]}
                                    : {1'b0, ser_sh[SER_W-1:1]};
        end
        if (out_edge) begin
            next_sdr_q = word[0];
        end
        if (serdes_en_i) begin
            out_val = ser_bit;
        end else if (dual_edge_mode_i) begin
            out_val = lau_s[1] ? out_hold[0] : out_hold[1];
        end else if (out_reg_en_i) begin
            out_val = sdr_q;
        end else begin
            out_val = word[0];
        end
        next_dly_out = {dly_out[DLY_LINE_LEN-2:0], out_val};
        next_pad_p   = tap(dly_out, out_idx, out_val);

        // drive enables, optionally registered on the launch clock
        next_oe_q  = oe_edge ? drive_enable_i : oe_q;
        next_oen_q = oe_edge ? drive_enable_pair_i : oen_q;
        oe_val     = oe_reg_en_i ? oe_q : drive_enable_i;
        next_pad_p_oe_n = ~oe_val;

        // pad pair as one differential or two single-ended ios
        if (diff_mode_i) begin
            next_pad_n      = ~next_pad_p;
            next_pad_n_oe_n = ~(oe_reg_en_i ? oen_q : drive_enable_pair_i);
        end else begin
            next_pad_n      = pad_n_drive_i;
            next_pad_n_oe_n = ~pad_n_enable_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_s      <= '0;
            lau_s      <= '0;
            cser_s     <= '0;
            lser_s     <= '0;
            pp_s       <= '0;
            pn_s       <= '0;
            dly_in     <= '0;
            dly_out    <= '0;
            cap_word   <= '0;
            deser_sh   <= '0;
            fall_hold  <= 1'b0;
            ser_sh     <= '0;
            ser_bit    <= 1'b0;
            out_hold   <= '0;
            sdr_q      <= 1'b0;
            oe_q       <= 1'b0;
            oen_q      <= 1'b0;
            pad_p      <= 1'b0;
            pad_p_oe_n <= 1'b1;
            pad_n      <= 1'b0;
            pad_n_oe_n <= 1'b1;
        end else begin
            cap_s      <= {cap_s[1:0], capture_clock_i};
            lau_s      <= {lau_s[1:0], launch_clock_i};
            cser_s     <= {cser_s[1:0], capture_serial_clock_i};
            lser_s     <= {lser_s[1:0], launch_serial_clock_i};
            pp_s       <= {pp_s[0], pad_p_i};
            pn_s       <= {pn_s[0], pad_n_i};
            dly_in     <= next_dly_in;
            dly_out    <= next_dly_out;
            cap_word   <= next_cap_word;
            deser_sh   <= next_deser_sh;
            fall_hold  <= next_fall_hold;
            ser_sh     <= next_ser_sh;
            ser_bit    <= next_ser_bit;
            out_hold   <= next_out_hold;
            sdr_q      <= next_sdr_q;
            oe_q       <= next_oe_q;
            oen_q      <= next_oen_q;
            pad_p      <= next_pad_p;
            pad_p_oe_n <= next_pad_p_oe_n;
            pad_n      <= next_pad_n;
            pad_n_oe_n <= next_pad_n_oe_n;
        end
    end

    // bypass taps the delayed pad ahead of any capture register
    assign bypass_path_o      = din;
    assign pad_capture_bits_o = cap_word;
    assign pad_n_capture_o    = pn_s[1];
    assign dyn_delay_o        = dyn;
    assign pad_p_o            = pad_p;
    assign pad_p_oe_n_o       = pad_p_oe_n;
    assign pad_n_o            = pad_n;
    assign pad_n_oe_n_o       = pad_n_oe_n;

    ////////////////////////////////////////////////////////////////////////
    // checks

    AST_DDR_RISE: assert property (@(posedge clk_i) disable iff (rst_i)
        !serdes_en_i && dual_edge_mode_i && cap_rise
        |=> pad_capture_bits_o[0] == $past(din))
        else $error("rising sample not on bit 0");

    AST_DDR_FALL: assert property (@(posedge clk_i) disable iff (rst_i)
        !serdes_en_i && dual_edge_mode_i && !resync_mode_i && cap_fall
        |=> pad_capture_bits_o[1] == $past(din))
        else $error("falling sample not on bit 1");

    AST_RESYNC_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
        !serdes_en_i && dual_edge_mode_i && resync_mode_i && !cap_rise
        ##1 !serdes_en_i && dual_edge_mode_i
        |-> $stable(pad_capture_bits_o))
        else $error("resync word changed off the rising edge");

    AST_RESYNC_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !serdes_en_i && dual_edge_mode_i && resync_mode_i && cap_fall
        ##1 (!cap_fall && !cap_rise && !serdes_en_i && dual_edge_mode_i
             && resync_mode_i) [*8]
        |-> fall_hold == $past(din, 8))
        else $error("held falling sample lost");

    AST_DESER: assert property (@(posedge clk_i) disable iff (rst_i)
        serdes_en_i && cap_rise |=> pad_capture_bits_o == $past(deser_sh))
        else $error("deserialized word not transferred");

    AST_SER_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
        serdes_en_i && lau_rise ##1 (!lau_rise && !lser_rise) [*8]
        ##1 lser_rise |=> ser_bit == $past(word[0], 10))
        else $error("serializer did not start with bit 0");

    AST_OE_REG: assert property (@(posedge clk_i) disable iff (rst_i)
        oe_reg_en_i && oe_edge ##1 oe_reg_en_i
        |=> pad_p_oe_n_o == !$past(drive_enable_i, 2))
        else $error("registered enable not on pad");

endmodule

// ---- testbench/fgil_core_model.sv ----
module fgil_core_model (
    // system clock
    input  wire logic clk_i,
    // io clock pins, still between requests
    output logic      capture_clock_o,
    output logic      launch_clock_o,
    output logic      capture_serial_clock_o,
    output logic      launch_serial_clock_o,
    // drive enables
    output logic      drive_enable_o,
    output logic      drive_enable_pair_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {capture_clock_o, launch_clock_o, capture_serial_clock_o,
         launch_serial_clock_o, drive_enable_o, drive_enable_pair_o} = '0;
    end

    ////////////////////////////////////////////////////////////
    // one pin moves per call; the rest after it covers the pin
    // synchronizers, the edge detect and the output flop
    task automatic pin(input int sel, input logic lvl);
        @(negedge clk_i);
        case (sel)
            0: capture_clock_o = lvl;
            1: launch_clock_o = lvl;
            2: capture_serial_clock_o = lvl;
            default: launch_serial_clock_o = lvl;
        endcase
        repeat (8) @(negedge clk_i);
    endtask

    task automatic enable(input logic v);
        @(negedge clk_i);
        drive_enable_o = v;
        drive_enable_pair_o = v;
    endtask
endmodule

// ---- testbench/fpga_gpio_io_logic_tb.sv ----
module fpga_gpio_io_logic_tb
    import fgil_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic             en;
        logic             dir;
        logic             clr;
        logic [DLY_W-1:0] exp;
    } fgil_row_t;

    // clear beats a step; no wrap below zero
    localparam fgil_row_t ROWS [10] = '{
        '{1'b1, 1'b1, 1'b1, 6'h00}, '{1'b1, 1'b1, 1'b0, 6'h01},
        '{1'b1, 1'b1, 1'b0, 6'h02}, '{1'b0, 1'b1, 1'b0, 6'h02},
        '{1'b1, 1'b0, 1'b0, 6'h01}, '{1'b1, 1'b0, 1'b0, 6'h00},
        '{1'b1, 1'b0, 1'b0, 6'h00}, '{1'b1, 1'b1, 1'b0, 6'h01},
        '{1'b0, 1'b0, 1'b0, 6'h01}, '{1'b1, 1'b1, 1'b1, 6'h00}
    };
    localparam logic [SER_W-1:0] SER_PAT = 4'hb;

    logic             clk_i, rst_i, capture_clock_i, launch_clock_i;
    logic             capture_serial_clock_i, launch_serial_clock_i;
    logic             dual_edge_mode_i, resync_mode_i, serdes_en_i;
    logic             diff_mode_i, in_reg_en_i, out_reg_en_i;
    logic             out_negedge_i, out_invert_i, oe_reg_en_i;
    logic             dyn_delay_sel_i, delay_step_enable_i;
    logic             delay_step_direction_i, delay_step_clear_i;
    logic             drive_enable_i, drive_enable_pair_i, pad_p_i;
    logic             in_negedge_i, pad_n_drive_i, pad_n_enable_i, pad_n_i;
    logic             pad_n_capture_o, pad_n_o, pad_n_oe_n_o;
    logic             bypass_path_o, pad_p_o, pad_p_oe_n_o;
    logic [DLY_W-1:0] in_static_delay_i, out_static_delay_i, dyn_delay_o;
    logic [SER_W-1:0] pad_drive_bits_i, pad_capture_bits_o;
    int               failures = 0;
    int               n_compared = 0;
    int               m0, n0, n;

    fgil_io_logic u_dut (
        .clk_i, .rst_i, .capture_clock_i, .launch_clock_i,
        .capture_serial_clock_i, .launch_serial_clock_i,
        .dual_edge_mode_i, .resync_mode_i, .serdes_en_i, .diff_mode_i,
        .in_reg_en_i, .in_negedge_i, .out_reg_en_i, .out_negedge_i,
        .out_invert_i, .oe_reg_en_i, .oe_negedge_i(1'b0),
        .in_static_delay_i, .out_static_delay_i, .dyn_delay_sel_i,
        .delay_step_enable_i, .delay_step_direction_i, .delay_step_clear_i,
        .dyn_delay_o, .pad_drive_bits_i, .drive_enable_i,
        .drive_enable_pair_i, .pad_capture_bits_o, .bypass_path_o,
        .pad_n_drive_i, .pad_n_enable_i, .pad_n_capture_o,
        .pad_p_i, .pad_n_i, .pad_p_o, .pad_p_oe_n_o, .pad_n_o,
        .pad_n_oe_n_o
    );

    fgil_core_model u_core (
        .clk_i,
        .capture_clock_o(capture_clock_i),
        .launch_clock_o(launch_clock_i),
        .capture_serial_clock_o(capture_serial_clock_i),
        .launch_serial_clock_o(launch_serial_clock_i),
        .drive_enable_o(drive_enable_i),
        .drive_enable_pair_o(drive_enable_pair_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // cycles from a data toggle until the pad or capture bit follows;
    // only differences are compared, so sync depth does not matter
    task automatic lat(input bit is_out, output int cnt);
        logic v;
        repeat (40) @(negedge clk_i);
        v = is_out ? ~pad_drive_bits_i[0] : ~pad_p_i;
        if (is_out) begin
            pad_drive_bits_i[0] = v;
        end else begin
            pad_p_i = v;
        end
        cnt = 0;
        while ((is_out ? pad_p_o : pad_capture_bits_o[0]) !== v) begin
            @(negedge clk_i);
            cnt++;
            if (cnt > 100) begin
                failures++;
                results();
            end
        end
    endtask

    task automatic dedge(input logic lvl, input logic d);
        pad_p_i = d;
        repeat (4) @(negedge clk_i);
        u_core.pin(0, lvl);
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        {dual_edge_mode_i, resync_mode_i, serdes_en_i, diff_mode_i,
         in_reg_en_i, out_reg_en_i, out_negedge_i, out_invert_i,
         oe_reg_en_i, dyn_delay_sel_i, delay_step_enable_i,
         delay_step_direction_i, delay_step_clear_i, pad_p_i, in_negedge_i,
         pad_n_drive_i, pad_n_enable_i, pad_n_i} = '0;
        in_static_delay_i = 6'h00;
        out_static_delay_i = 6'h00;
        pad_drive_bits_i = 4'h0;
        rst_i = 1'b1;
        repeat (16) @(negedge clk_i);
        check("cap", 8'(pad_capture_bits_o), 8'h00);
        check("oe_n", 8'(pad_p_oe_n_o), 8'h01);
        check("dly", 8'(dyn_delay_o), 8'h00);
        rst_i = 1'b0;
        {delay_step_enable_i, delay_step_direction_i} = 2'b11;
        repeat (DYN_STEPS + 3) @(negedge clk_i);
        check("dly", 8'(dyn_delay_o), 8'(DYN_STEPS - 1));
        delay_step_clear_i = 1'b1;
        @(negedge clk_i);
        check("dly", 8'(dyn_delay_o), 8'(DYN_DELAY_STEP_CLEAR));
        {delay_step_enable_i, delay_step_clear_i} = 2'b00;
        lat(1'b1, m0);
        lat(1'b0, n0);
        in_static_delay_i = 6'h15;
        lat(1'b0, n);
        check("in_dly", 8'(n - n0), 8'h05);
        diff_mode_i = 1'b1;
        lat(1'b0, n);
        check("in_dly", 8'(n - n0), 8'h15);
        {dyn_delay_sel_i, delay_step_enable_i} = 2'b11;
        repeat (3) @(negedge clk_i);
        delay_step_enable_i = 1'b0;
        lat(1'b0, n);
        check("in_dly", 8'(n - n0), 8'h03);
        {diff_mode_i, dyn_delay_sel_i} = 2'b00;
        lat(1'b0, n);
        check("in_dly", 8'(n - n0), 8'h08);
        out_static_delay_i = 6'h15;
        lat(1'b1, n);
        check("out_dly", 8'(n - m0), 8'h05);
        in_static_delay_i = 6'h00;
        out_static_delay_i = 6'h00;
        foreach (ROWS[i]) begin
            delay_step_enable_i = ROWS[i].en;
            delay_step_direction_i = ROWS[i].dir;
            delay_step_clear_i = ROWS[i].clr;
            @(negedge clk_i);
            check("dly", 8'(dyn_delay_o), 8'(ROWS[i].exp));
        end
        {delay_step_enable_i, delay_step_clear_i} = 2'b00;
        dual_edge_mode_i = 1'b1;
        for (int r = 0; r < 2; r++) begin
            resync_mode_i = r[0];
            dedge(1'b1, 1'b1);
            dedge(1'b0, 1'b0);
            dedge(1'b1, 1'b0);
            check("cap", 8'(pad_capture_bits_o), 8'h00);
            dedge(1'b0, 1'b1);
            check("cap", 8'(pad_capture_bits_o), r ? 8'h00 : 8'h02);
            dedge(1'b1, 1'b1);
            check("cap", 8'(pad_capture_bits_o), 8'h03);
            dedge(1'b0, 1'b0);
            check("cap", 8'(pad_capture_bits_o), r ? 8'h03 : 8'h01);
        end
        pad_p_i = 1'b1;
        repeat (6) @(negedge clk_i);
        check("byp", 8'(bypass_path_o), 8'h01);
        check("cap", 8'(pad_capture_bits_o), 8'h03);
        {dual_edge_mode_i, resync_mode_i, serdes_en_i} = 3'b001;
        for (int i = 0; i < SER_W; i++) begin
            pad_p_i = SER_PAT[i];
            repeat (4) @(negedge clk_i);
            u_core.pin(2, 1'b1);
            u_core.pin(2, 1'b0);
        end
        u_core.pin(0, 1'b1);
        check("cap", 8'(pad_capture_bits_o), 8'(SER_PAT));
        u_core.pin(0, 1'b0);
        pad_drive_bits_i = SER_PAT;
        oe_reg_en_i = 1'b1;
        u_core.enable(1'b1);
        repeat (4) @(negedge clk_i);
        check("oe_n", 8'(pad_p_oe_n_o), 8'h01);
        u_core.pin(1, 1'b1);
        check("oe_n", 8'(pad_p_oe_n_o), 8'h00);
        for (int i = 0; i < SER_W; i++) begin
            u_core.pin(3, 1'b1);
            check("pad", 8'(pad_p_o), 8'(SER_PAT[i]));
            u_core.pin(3, 1'b0);
        end
        u_core.pin(1, 1'b0);
        {serdes_en_i, dual_edge_mode_i} = 2'b01;
        pad_drive_bits_i = 4'h1;
        for (int k = 0; k < 2; k++) begin
            out_invert_i = k[0];
            u_core.pin(1, 1'b1);
            check("pad", 8'(pad_p_o), k ? 8'h00 : 8'h01);
            u_core.pin(1, 1'b0);
            check("pad", 8'(pad_p_o), k ? 8'h01 : 8'h00);
        end
        {dual_edge_mode_i, out_invert_i} = 2'b00;
        {out_reg_en_i, out_negedge_i} = 2'b11;
        pad_drive_bits_i = 4'h0;
        u_core.pin(1, 1'b1);
        u_core.pin(1, 1'b0);
        pad_drive_bits_i = 4'h1;
        u_core.pin(1, 1'b1);
        check("pad", 8'(pad_p_o), 8'h00);
        u_core.pin(1, 1'b0);
        check("pad", 8'(pad_p_o), 8'h01);
        // second pad on its own, then slaved to the first as a pair
        {pad_n_drive_i, pad_n_enable_i, pad_n_i} = 3'b111;
        repeat (3) @(negedge clk_i);
        check("pad_n", 8'({pad_n_o, pad_n_oe_n_o, pad_n_capture_o}),
              8'h05);
        diff_mode_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check("pad_n", 8'({pad_n_o, pad_n_oe_n_o}), 8'h00);
        diff_mode_i = 1'b0;
        // registered single-rate input on the falling capture edge
        {in_reg_en_i, in_negedge_i, pad_p_i} = 3'b110;
        repeat (6) @(negedge clk_i);
        check("cap", 8'(pad_capture_bits_o), 8'h01);
        u_core.pin(0, 1'b1);
        check("cap", 8'(pad_capture_bits_o), 8'h01);
        u_core.pin(0, 1'b0);
        check("cap", 8'(pad_capture_bits_o), 8'h00);
        results();
    end
endmodule
